/* hdl/arc_serial_readout.sv */
// Purpose: result readout of a converter: trigger, mode choice, busy bit, serial shift
// Assumes: host keeps its own timing duties; sample_code is on ref_clk
// Notes:   serial clock logic is its own domain, fed raw; pins are synchronised before ref_clk use
//
// What this block does
// - 3-wire busy mode: trigger rise tristates output, samples, starts internal conversion.
// - Busy-indicator end: enter acquisition, enable output, drive a low busy bit.
// - After the busy bit, shift the result MSB first on serial clock falls.
// - 3-wire busy mode: tristate after 17th fall or when trigger rises.
// - 4-wire: trigger rise with chain input high selects chip-select mode and converts.
// - 4-wire no busy: chain input fall enables output with MSB, then shifts.
// - 4-wire no busy: tristate after 16th fall or when chain input rises.
// - 4-wire busy mode: tristate after 17th fall or when chain input rises.
// - Chain input low at trigger rise selects daisy-chain mode.
// - Drive the output low whenever trigger and chain input are both low.
// - Daisy mode: serial clock low at trigger rise means no busy bit.
// - Daisy end without busy: load 16-bit shift register, present its MSB.
// - Each later fall captures chain input and presents the next bit.
// - The result is the two's complement code of the differential input.
// - 3-wire no busy: trigger fall enables output with MSB; 16 falls then tristate.
// - Daisy mode: serial clock high at trigger rise forces a high busy bit first.

package arc_pkg;

    localparam int WORD_BITS   = 16;
    localparam int CNT_W       = 5;
    localparam int REF_CLK_MHZ = 125;
    localparam int CONV_TIME_NS = 700;
    localparam int CONV_CYCLES = (CONV_TIME_NS * REF_CLK_MHZ + 999) / 1000;
    localparam int CONV_W      = 8;

    localparam logic [CNT_W-1:0] CNT_LIMIT_PLAIN = 5'h10;
    localparam logic [CNT_W-1:0] CNT_LIMIT_BUSY  = 5'h11;

    localparam logic CS_BUSY_LEVEL    = 1'h0;
    localparam logic DAISY_BUSY_LEVEL = 1'h1;

    localparam int PIN_TRIG  = 2;
    localparam int PIN_CHAIN = 1;
    localparam int PIN_SCLK  = 0;
    localparam int PIN_COUNT = 3;

    localparam logic [WORD_BITS-1:0] WORD_RESET = 16'h0000;

    typedef enum logic [1:0] {
        ST_ACQ   = 2'h0,
        ST_CONV  = 2'h1,
        ST_WAIT  = 2'h2,
        ST_SHIFT = 2'h3
    } arc_state_type;

    typedef struct packed {
        arc_state_type        state;
        logic [CONV_W-1:0]    conv_cnt;
        logic                 daisy;
        logic                 daisy_busy;
        logic                 busy_en;
        logic [WORD_BITS-1:0] sample;
        logic [WORD_BITS-1:0] word;
        logic                 trig_prev;
        logic                 link_run;
    } arc_core_type;

endpackage

`timescale 1ns/1ps
`default_nettype none

module arc_serial_readout #(
    parameter int CONV_CYCLES = arc_pkg::CONV_CYCLES
) (
    input  wire logic                         ref_clk,
    input  wire logic                         resetn,
    input  wire logic                         serial_clock,
    input  wire logic                         conversion_trigger,
    input  wire logic                         chain_in,
    input  wire logic [arc_pkg::WORD_BITS-1:0] sample_code,
    output logic                              serial_data_out,
    output logic                              serial_data_oe_n,
    output logic                              converting
);

    localparam logic [arc_pkg::CONV_W-1:0] CONV_LAST =
        arc_pkg::CONV_W'(CONV_CYCLES - 1);

    generate
        if (CONV_CYCLES < 1 || CONV_CYCLES > (1 << arc_pkg::CONV_W)) begin : g_bad_conv
            $error("arc_serial_readout: CONV_CYCLES out of range");
        end
    endgenerate

    arc_pkg::arc_core_type st_q;
    arc_pkg::arc_core_type st_d;

    logic [arc_pkg::PIN_COUNT-1:0] pins_s;
    logic                          trig_s;
    logic                          chain_s;
    logic                          sclk_s;
    logic                          trig_rise;
    logic                          selected;
    logic                          both_low;
    logic [arc_pkg::CNT_W-1:0]     fall_count;
    logic                          chain_bit;
    logic                          link_rstn;

    // Selects the bit on the line after k serial clock falls
    function automatic logic pick_bit(
        input logic [arc_pkg::WORD_BITS-1:0] word,
        input logic [arc_pkg::CNT_W-1:0]     k,
        input logic                          busy_en,
        input logic                          busy_level,
        input logic                          chain_bit
    );
        logic [arc_pkg::CNT_W-1:0] idx;
        idx = k;
        if (busy_en) begin
            if (k == '0) begin
                return busy_level;
            end
            idx = k - arc_pkg::CNT_W'(1);
        end
        if (idx >= arc_pkg::CNT_W'(arc_pkg::WORD_BITS)) begin
            return chain_bit;
        end
        return word[arc_pkg::WORD_BITS - 1 - 32'(idx)];
    endfunction

    arc_sync #(
        .WIDTH (arc_pkg::PIN_COUNT)
    ) u_pin_sync (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .async_in ({conversion_trigger, chain_in, serial_clock}),
        .sync_out (pins_s)
    );

    assign trig_s    = pins_s[arc_pkg::PIN_TRIG];
    assign chain_s   = pins_s[arc_pkg::PIN_CHAIN];
    assign sclk_s    = pins_s[arc_pkg::PIN_SCLK];
    assign trig_rise = trig_s & ~st_q.trig_prev;
    // Either line low means the host is selecting this converter
    assign selected  = ~(trig_s & chain_s);
    assign both_low  = ~trig_s & ~chain_s;

    // Registered level, so the link side sees a clean clear between readouts
    assign link_rstn = st_q.link_run;

    arc_link_shift #(
        .WORD_BITS (arc_pkg::WORD_BITS),
        .CNT_W     (arc_pkg::CNT_W)
    ) u_link (
        .serial_clock (serial_clock),
        .link_rstn    (link_rstn),
        .chain_in     (chain_in),
        .fall_count   (fall_count),
        .chain_bit    (chain_bit)
    );

    always_comb begin
        st_d           = st_q;
        st_d.trig_prev = trig_s;
        unique case (st_q.state)
            arc_pkg::ST_ACQ, arc_pkg::ST_WAIT, arc_pkg::ST_SHIFT: begin
                if (trig_rise) begin
                    // Conversion start wins over any readout still running
                    st_d.state      = arc_pkg::ST_CONV;
                    st_d.conv_cnt   = CONV_LAST;
                    st_d.sample     = sample_code;
                    st_d.daisy      = ~chain_s;
                    st_d.daisy_busy = sclk_s;
                    st_d.link_run   = 1'b0;
                end else if (st_q.state == arc_pkg::ST_WAIT) begin
                    if (selected) begin
                        st_d.state    = arc_pkg::ST_SHIFT;
                        st_d.link_run = 1'b1;
                    end
                end else if (st_q.state == arc_pkg::ST_SHIFT && !st_q.daisy) begin
                    if (!selected) begin
                        st_d.state    = arc_pkg::ST_ACQ;
                        st_d.link_run = 1'b0;
                    end
                end
            end
            arc_pkg::ST_CONV: begin
                // Runs on ref_clk alone; pin activity cannot disturb it
                if (st_q.conv_cnt != '0) begin
                    st_d.conv_cnt = st_q.conv_cnt - arc_pkg::CONV_W'(1);
                end else begin
                    st_d.word = st_q.sample;
                    if (st_q.daisy) begin
                        st_d.busy_en  = st_q.daisy_busy;
                        st_d.state    = arc_pkg::ST_SHIFT;
                        st_d.link_run = 1'b1;
                    end else if (selected) begin
                        st_d.busy_en  = 1'b1;
                        st_d.state    = arc_pkg::ST_SHIFT;
                        st_d.link_run = 1'b1;
                    end else begin
                        st_d.busy_en  = 1'b0;
                        st_d.state    = arc_pkg::ST_WAIT;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_q.state      <= arc_pkg::ST_ACQ;
            st_q.conv_cnt   <= '0;
            st_q.daisy      <= 1'b0;
            st_q.daisy_busy <= 1'b0;
            st_q.busy_en    <= 1'b0;
            st_q.sample     <= arc_pkg::WORD_RESET;
            st_q.word       <= arc_pkg::WORD_RESET;
            st_q.trig_prev  <= 1'b1; // Same level as the synchroniser reset
            st_q.link_run   <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // Pin stage mixes both domains on purpose: the count must act on the
    // very fall it reaches, with no crossing delay in between
    logic                      drive;
    logic                      data_bit;
    logic [arc_pkg::CNT_W-1:0] cnt_limit;

    always_comb begin
        cnt_limit = st_q.busy_en ? arc_pkg::CNT_LIMIT_BUSY : arc_pkg::CNT_LIMIT_PLAIN;
        data_bit  = pick_bit(st_q.word, fall_count, st_q.busy_en,
                             st_q.daisy ? arc_pkg::DAISY_BUSY_LEVEL
                                        : arc_pkg::CS_BUSY_LEVEL,
                             chain_bit);
        drive     = 1'b0;
        if (st_q.state == arc_pkg::ST_SHIFT) begin
            if (st_q.daisy) begin
                drive = 1'b1;
            end else begin
                drive = selected && (fall_count < cnt_limit);
            end
        end
        if (both_low) begin
            drive    = 1'b1;
            data_bit = 1'b0;
        end
    end

    assign serial_data_out  = drive ? data_bit : 1'b0;
    assign serial_data_oe_n = ~drive;
    assign converting       = (st_q.state == arc_pkg::ST_CONV);

endmodule // arc_serial_readout

`default_nettype wire

/* hdl/arc_sync.sv */
// Purpose: two-flop synchroniser for pin levels entering the ref_clk domain
// Assumes: inputs are slow levels compared with ref_clk, or only their level matters
// Notes:   the first stage feeds the second stage only
`timescale 1ns/1ps
`default_nettype none

module arc_sync #(
    parameter int WIDTH = 3
) (
    input  wire logic             ref_clk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] held;
    } arc_sync_state_type;

    arc_sync_state_type st_q;
    arc_sync_state_type st_d;

    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("arc_sync: WIDTH must be at least 1");
        end
    endgenerate

    always_comb begin
        st_d      = st_q;
        st_d.meta = async_in;
        st_d.held = st_q.meta;
    end

    // Resets to the idle-high pin level, so no false trigger edge follows reset
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '1;
        end else begin
            st_q <= st_d;
        end
    end

    assign sync_out = st_q.held;

endmodule // arc_sync

`default_nettype wire

/* hdl/arc_link_shift.sv */
// Purpose: serial-clock side of the readout: counts falling edges, captures chain input
// Assumes: link_rstn is a registered level from the ref_clk side, low outside a readout
// Notes:   the serial clock may stand still; nothing here needs an edge outside a readout
`timescale 1ns/1ps
`default_nettype none

module arc_link_shift #(
    parameter int WORD_BITS = 16,
    parameter int CNT_W     = 5
) (
    input  wire logic             serial_clock,
    input  wire logic             link_rstn,
    input  wire logic             chain_in,
    output logic      [CNT_W-1:0] fall_count,
    output logic                  chain_bit
);

    typedef struct packed {
        logic [CNT_W-1:0]     cnt;
        logic [WORD_BITS-1:0] hist;
    } arc_link_state_type;

    localparam logic [CNT_W-1:0] CNT_SAT = CNT_W'(WORD_BITS + 1);

    arc_link_state_type st_q;
    arc_link_state_type st_d;

    generate
        if (WORD_BITS < 2 || (WORD_BITS + 1) >= (1 << CNT_W)) begin : g_bad_cfg
            $error("arc_link_shift: CNT_W too narrow for WORD_BITS");
        end
    endgenerate

    // Count saturates: past the own word only the chain history matters
    always_comb begin
        st_d      = st_q;
        if (st_q.cnt != CNT_SAT) begin
            st_d.cnt = st_q.cnt + CNT_W'(1);
        end
        st_d.hist = {st_q.hist[WORD_BITS-2:0], chain_in};
    end

    // Cleared asynchronously while no readout runs, so the first fall is counted
    always_ff @(negedge serial_clock or negedge link_rstn) begin
        if (!link_rstn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign fall_count = st_q.cnt;
    // Bit captured fifteen falls ago leaves this device once the own word is out
    assign chain_bit  = st_q.hist[WORD_BITS-1];

endmodule // arc_link_shift

`default_nettype wire

/* tb/arc_readout_monitor.sv */
// Purpose: port assertions for arc_serial_readout
// Assumes: pins change on ref_clk edges; link counts are judged by the bench
// Notes:   pin effects pass a 2-flop sync, hence the 4-cycle windows
`timescale 1ns/1ps
`default_nettype none

module arc_readout_monitor #(
    parameter int CONV_CYCLES = 88
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic serial_clock,
    input wire logic conversion_trigger,
    input wire logic chain_in,
    input wire logic serial_data_out,
    input wire logic serial_data_oe_n,
    input wire logic converting
);
    logic [7:0] len_q;
    logic       trig_prev_q;
    logic       daisy_q;
    logic       daisy_busy_q;
    logic       conv_prev_q;
    logic       wait_q;

    // Mode is judged from raw pins at trigger rise; pins stand still around it
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            len_q        <= 8'h00;
            trig_prev_q  <= 1'h1;
            daisy_q      <= 1'h0;
            daisy_busy_q <= 1'h0;
            conv_prev_q  <= 1'h0;
            wait_q       <= 1'h0;
        end else begin
            len_q       <= converting ? len_q + 8'h01 : 8'h00;
            trig_prev_q <= conversion_trigger;
            conv_prev_q <= converting;
            if (conversion_trigger && !trig_prev_q && !converting) begin
                daisy_q      <= !chain_in;
                daisy_busy_q <= serial_clock;
            end
            // Unread plain chip-select result: only then must a select open the output
            if (converting || !serial_data_oe_n) begin
                wait_q <= 1'h0;
            end else if (conv_prev_q && conversion_trigger && chain_in && !daisy_q) begin
                wait_q <= 1'h1;
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    conv_start_a: assert property (
        $rose(conversion_trigger) && !converting |-> ##[1:5] $rose(converting))
        else $error("no conversion after trigger rise");
    conv_len_a: assert property (
        $fell(converting) |-> len_q == 8'(CONV_CYCLES))
        else $error("conversion length wrong");
    conv_tri_a: assert property (
        converting && conversion_trigger |-> serial_data_oe_n)
        else $error("output driven during conversion");
    both_low_a: assert property (
        (!conversion_trigger && !chain_in)[*4] |-> !serial_data_oe_n && !serial_data_out)
        else $error("both pins low but output not driven low");
    busy_low_a: assert property (
        $fell(converting) && !daisy_q && !(conversion_trigger && chain_in)
        |-> !serial_data_oe_n && !serial_data_out)
        else $error("missing low busy bit");
    daisy_busy_a: assert property (
        $fell(converting) && daisy_q && daisy_busy_q |-> !serial_data_oe_n && serial_data_out)
        else $error("missing high busy bit");
    deselect_tri_a: assert property (
        (!daisy_q && conversion_trigger && chain_in)[*4] |-> serial_data_oe_n)
        else $error("output driven while deselected");
    select_out_a: assert property (
        $fell(chain_in) && conversion_trigger && !converting && serial_data_oe_n && wait_q
        |-> ##[2:5] !serial_data_oe_n)
        else $error("select did not enable output");
endmodule // arc_readout_monitor

bind arc_serial_readout arc_readout_monitor #(.CONV_CYCLES(CONV_CYCLES)) i_mon (
    .ref_clk, .resetn, .serial_clock, .conversion_trigger, .chain_in,
    .serial_data_out, .serial_data_oe_n, .converting);

`default_nettype wire

/* tb/arc_host.sv */
// Purpose: host side of the readout: serial clock frames and bit capture
// Assumes: go pulses high once per frame
// Notes:   clock stands at idle_hi between frames; released line reads the pull-up
`timescale 1ns/1ps
`default_nettype none

module arc_host (
    input  wire logic        go,
    input  wire logic [5:0]  n_falls,
    input  wire logic        idle_hi,
    input  wire logic        sdo,
    input  wire logic        sdo_oe_n,
    output logic             sclk,
    output logic [47:0]      rx,
    output logic             done
);
    // One process owns every output, so the clock moves only inside a frame or to follow idle_hi
    initial begin
        sclk = 1'h0;
        rx   = 48'h0;
        done = 1'h1;
        forever begin
            @(posedge go or idle_hi);
            if (go) begin
                done = 1'h0;
                rx   = 48'h0;
                #1.3;
                repeat (n_falls) begin
                    sclk = 1'h1;
                    rx   = {rx[46:0], sdo_oe_n ? 1'h1 : sdo};
                    #3 sclk = 1'h0;
                    #3;
                end
                done = 1'h1;
            end
            sclk = idle_hi;
        end
    end
endmodule // arc_host

`default_nettype wire

/* tb/tb_top.sv */
// Purpose: self-checking bench for arc_serial_readout
// Assumes: conversion shortened to 8 ref_clk cycles
// Notes:   daisy cases run last since daisy drives until the next trigger rise
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic                          ref_clk = 1'h0;
    logic                          resetn = 1'h0;
    logic                          trig = 1'h1;
    logic                          chain = 1'h1;
    logic [arc_pkg::WORD_BITS-1:0] code = 16'h0000;
    logic                          go = 1'h0;
    logic [5:0]                    nf = 6'h00;
    logic                          idle_hi = 1'h0;
    logic                          sclk, sdo, oe_n, conv, done;
    logic [47:0]                   rx;
    int                            error_cnt = 0;
    int                            n_checks = 0;

    arc_serial_readout #(.CONV_CYCLES(8)) i_arc_serial_readout (
        .ref_clk(ref_clk), .resetn(resetn), .serial_clock(sclk),
        .conversion_trigger(trig), .chain_in(chain), .sample_code(code),
        .serial_data_out(sdo), .serial_data_oe_n(oe_n), .converting(conv));
    arc_host i_arc_host (.go(go), .n_falls(nf), .idle_hi(idle_hi), .sdo(sdo),
        .sdo_oe_n(oe_n), .sclk(sclk), .rx(rx), .done(done));

    initial forever #4 ref_clk = ~ref_clk;

    task automatic chk_bit(input logic g, input logic e);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch at %0t: pin level", $time);
        end
    endtask
    task automatic chk_word(input logic [47:0] g, input logic [47:0] e);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch at %0t: read word %h", $time, g);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic pins(input logic t, input logic c);
        @(posedge ref_clk);
        trig <= t;
        chain <= c;
    endtask
    task automatic conv_done;
        int i;
        for (i = 0; i < 20 && conv !== 1'h1; i++) @(posedge ref_clk);
        #1;
        chk_bit(conv, 1'h1);
        for (i = 0; i < 20 && conv !== 1'h0; i++) @(posedge ref_clk);
        wait_cyc(3);
        chk_bit(conv, 1'h0);
    endtask
    task automatic clk_out(input logic [5:0] n);
        int i;
        nf <= n;
        go <= 1'h1;
        @(posedge ref_clk);
        go <= 1'h0;
        for (i = 0; i < 100 && done !== 1'h1; i++) @(posedge ref_clk);
        wait_cyc(1);
        chk_bit(done, 1'h1);
    endtask

    task automatic t_cs3_busy;
        @(posedge ref_clk);
        code <= 16'hA5C3;
        pins(1'h0, 1'h1);
        pins(1'h0, 1'h1);
        pins(1'h1, 1'h1);
        pins(1'h1, 1'h1);
        pins(1'h0, 1'h1);
        conv_done;
        chk_bit(oe_n, 1'h0);
        chk_bit(sdo, 1'h0);
        clk_out(6'h11);
        chk_word(rx, 48'h0000_0000_A5C3);
        chk_bit(oe_n, 1'h1);
        pins(1'h1, 1'h1);
        conv_done;
    endtask
    task automatic t_cs4_plain;
        @(posedge ref_clk);
        code <= 16'hC35A;
        pins(1'h0, 1'h1);
        pins(1'h0, 1'h1);
        pins(1'h1, 1'h1);
        conv_done;
        chk_bit(oe_n, 1'h1);
        pins(1'h1, 1'h0);
        wait_cyc(4);
        chk_bit(oe_n, 1'h0);
        chk_bit(sdo, 1'h1);
        clk_out(6'h10);
        chk_word(rx, 48'h0000_0000_C35A);
        chk_bit(oe_n, 1'h1);
        pins(1'h1, 1'h1);
    endtask
    task automatic t_cs4_busy_abort;
        code <= 16'h8001;
        pins(1'h0, 1'h1);
        pins(1'h0, 1'h1);
        pins(1'h1, 1'h1);
        wait_cyc(4);
        pins(1'h1, 1'h0);
        conv_done;
        chk_bit(oe_n, 1'h0);
        chk_bit(sdo, 1'h0);
        clk_out(6'h05);
        chk_word(rx, 48'h0000_0000_0008);
        pins(1'h1, 1'h1);
        wait_cyc(4);
        chk_bit(oe_n, 1'h1);
    endtask
    task automatic t_daisy;
        @(posedge ref_clk);
        code <= 16'h9C4E;
        pins(1'h0, 1'h0);
        wait_cyc(4);
        chk_bit(oe_n, 1'h0);
        chk_bit(sdo, 1'h0);
        pins(1'h1, 1'h0);
        conv_done;
        chk_bit(sdo, 1'h1);
        pins(1'h1, 1'h1);
        clk_out(6'h20);
        chk_word(rx, 48'h0000_9C4E_FFFF);
    endtask
    task automatic t_daisy_busy;
        @(posedge ref_clk);
        code <= 16'h3F81;
        idle_hi <= 1'h1;
        pins(1'h0, 1'h0);
        pins(1'h0, 1'h0);
        pins(1'h1, 1'h0);
        conv_done;
        chk_bit(sdo, 1'h1);
        clk_out(6'h11);
        chk_word(rx, 48'h0000_0001_3F81);
        idle_hi <= 1'h0;
    endtask

    task automatic finish_test;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Whole run is under two thousand ns; generous margin before declaring a hang
    initial begin
        #20000;
        error_cnt++;
        finish_test;
    end

    initial begin
        repeat (5) @(posedge ref_clk);
        resetn <= 1'h1;
        wait_cyc(3);
        t_cs3_busy;
        t_cs4_plain;
        t_cs4_busy_abort;
        t_daisy;
        t_daisy_busy;
        finish_test;
    end
endmodule // tb_top

`default_nettype wire
